// ==== hw/dtec_params.svh ====
`ifndef DTEC_PARAMS_SVH
`define DTEC_PARAMS_SVH

// Register offsets on the plain register port.
`define DTEC_ADDR_MODE    3'h0
`define DTEC_ADDR_CTRL    3'h1
`define DTEC_ADDR_C0_LOW  3'h2
`define DTEC_ADDR_C0_HIGH 3'h3
`define DTEC_ADDR_C1_LOW  3'h4
`define DTEC_ADDR_C1_HIGH 3'h5
`define DTEC_ADDR_STATUS  3'h6
`define DTEC_ADDR_MASK    3'h7

// Mode register fields, channel 0 in the low nibble.
`define DTEC_MODE_SEL0    1:0
`define DTEC_MODE_SRC0    2
`define DTEC_MODE_GATING_ENABLE   3
`define DTEC_MODE_SEL1    5:4
`define DTEC_MODE_SRC1    6
`define DTEC_MODE_GATE1   7

// Control register fields.
`define DTEC_CTRL_ITYPE0  0
`define DTEC_CTRL_IFLAG0  1
`define DTEC_CTRL_ITYPE1  2
`define DTEC_CTRL_IFLAG1  3
`define DTEC_CTRL_RUN0    4
`define DTEC_CTRL_OVF0    5
`define DTEC_CTRL_RUN1    6
`define DTEC_CTRL_OVF1    7

// Interrupt status and mask fields.
`define DTEC_IRQ_OVF0     0
`define DTEC_IRQ_OVF1     1
`define DTEC_IRQ_EXT0     2
`define DTEC_IRQ_EXT1     3

// Reset values.
`define DTEC_RST_BYTE     8'h00
`define DTEC_RST_IRQ      4'h0

// Peripheral clock periods in one peripheral cycle.
`define DTEC_PER_PERIODS  6
`define DTEC_DIV_MAX      3'h5

`endif

// ==== hw/dtec_pkg.sv ====
package dtec_pkg;

  typedef enum logic [1:0] {
    DTEC_MODE_13BIT  = 2'b00,
    DTEC_MODE_16BIT  = 2'b01,
    DTEC_MODE_RELOAD = 2'b10,
    DTEC_MODE_SPLIT  = 2'b11
  } dtec_mode_t;

endpackage

// ==== hw/dtec_pin_if.sv ====
`timescale 1ns/100ps

interface dtec_pin_if;
  logic       per_tick;
  logic [1:0] cnt_fall;
  logic [1:0] irq_fall;
  logic [1:0] irq_level;

  modport src (
    output per_tick,
    output cnt_fall,
    output irq_fall,
    output irq_level
  );

  modport dst (
    input per_tick,
    input cnt_fall,
    input irq_fall,
    input irq_level
  );
endinterface

// ==== hw/dtec_divider.sv ====
`timescale 1ns/100ps
`include "dtec_params.svh"

module dtec_divider (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // Peripheral cycle pulse
  output logic      tick
);

  logic [2:0] div_reg;

  // ----------------------------------------
  // Peripheral cycle divider
  // ----------------------------------------
  // six clock periods
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_reg <= 3'h0;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_reg == `DTEC_DIV_MAX);
      div_reg <= (div_reg == `DTEC_DIV_MAX) ? 3'h0 : div_reg + 3'h1;
    end
  end

endmodule

// ==== hw/dtec_pinsamp.sv ====
`timescale 1ns/100ps

module dtec_pinsamp (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Peripheral cycle pulse
  input  wire logic       tick,
  // Raw pins
  input  wire logic [1:0] count_pin,
  input  wire logic [1:0] ext_irq_pin_n,
  // Sampled results
  dtec_pin_if.src         pins
);

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] smp_reg;
  logic [3:0] fall_reg;

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end else begin
      sync1_reg <= {ext_irq_pin_n, count_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // Per-cycle sampling and edge detection
  // ----------------------------------------
  // sample each cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      smp_reg  <= 4'hF;
      fall_reg <= 4'h0;
    end else if (tick) begin
      smp_reg  <= sync2_reg;
      fall_reg <= smp_reg & ~sync2_reg;
    end else begin
      fall_reg <= 4'h0;
    end
  end

  assign pins.per_tick  = tick;
  assign pins.cnt_fall  = fall_reg[1:0];
  assign pins.irq_fall  = fall_reg[3:2];
  assign pins.irq_level = smp_reg[3:2];

endmodule

// ==== hw/dtec_top.sv ====
// Overview of operation
// - Two independent 16-bit channels, each a timer or event counter.
// - Counter operation counts falling pin edges; overflow requests irq.
// - High and low bytes cascade; run bit lets input increment low byte.
// - Low overflow increments high; high overflow sets overflow flag.
// - Setting run bit keeps count bytes; counting resumes from them.
// - Counts readable anytime; software stops channel before presetting.
// - Source select 0 counts peripheral cycles, 1 counts pin edges.
// - Timer increments once per peripheral cycle of six clocks.
// - Pin sampled each peripheral cycle; high then low increments.
// - Edge recognition takes two cycles; max rate is clock over twelve.
// - Channel zero has four modes, low mode nibble, control bits 0,1,4,5.
// - Mode nibble: gate, source, mode bits; control: flags, run, type.
// - Without gating run alone counts; with gating irq pin also gates.
// - Channel zero rollover sets overflow flag and requests interrupt.
// - Mode 0 is 13-bit: high byte fed by five-bit low prescaler.
// - Mode 1 is full 16-bit cascade of high and low bytes.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "dtec_params.svh"

module dtec_top (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // External pins
  input  wire logic [1:0] count_pin,
  input  wire logic [1:0] ext_irq_pin_n,
  // Interrupt
  output logic            irq
);

  logic       tick;
  logic [7:0] mode_register_reg;
  logic [1:0] run_bit_reg;
  logic [1:0] overflow_flag_reg;
  logic [1:0] ext_irq_flag_reg;
  logic [1:0] ext_irq_type_reg;
  logic [7:0] c0_low_reg;
  logic [7:0] c0_high_reg;
  logic [7:0] c1_low_reg;
  logic [7:0] c1_high_reg;
  logic [3:0] status_reg;
  logic [3:0] mask_reg;

  logic [7:0] c0_low_next;
  logic [7:0] c0_high_next;
  logic [7:0] c1_low_next;
  logic [7:0] c1_high_next;
  logic [1:0] ovf_evt;
  logic [1:0] ext_evt;
  logic [3:0] status_next;
  logic [3:0] mask_next;
  logic       en0;
  logic       en1;
  logic       en0_high;
  logic [16:0] step0;
  logic [16:0] step1;

  dtec_pkg::dtec_mode_t mode0;
  dtec_pkg::dtec_mode_t mode1;

  dtec_pin_if pins ();

  dtec_divider u_div (
    .mclk (mclk),
    .rstn (rstn),
    .tick (tick)
  );

  dtec_pinsamp u_samp (
    .mclk          (mclk),
    .rstn          (rstn),
    .tick          (tick),
    .count_pin     (count_pin),
    .ext_irq_pin_n (ext_irq_pin_n),
    .pins          (pins)
  );

  // ----------------------------------------
  // Count step
  // ----------------------------------------
  // Returns {overflow, high, low} after one increment in modes 0 to 2.
  function automatic logic [16:0] count_step(
    input dtec_pkg::dtec_mode_t mode,
    input logic [7:0]           high,
    input logic [7:0]           low
  );
    logic [8:0] lo9;
    logic [8:0] hi9;
    logic [5:0] pre;
    count_step = {1'b0, high, low};
    case (mode)
      dtec_pkg::DTEC_MODE_13BIT: begin
        pre = {1'b0, low[4:0]} + 6'h01;
        hi9 = {1'b0, high} + {8'h00, pre[5]};
        count_step = {hi9[8], hi9[7:0], low[7:5], pre[4:0]};
      end
      dtec_pkg::DTEC_MODE_16BIT: begin
        lo9 = {1'b0, low} + 9'h001;
        hi9 = {1'b0, high} + {8'h00, lo9[8]};
        count_step = {hi9[8], hi9[7:0], lo9[7:0]};
      end
      dtec_pkg::DTEC_MODE_RELOAD: begin
        lo9 = {1'b0, low} + 9'h001;
        count_step = {lo9[8], high, lo9[8] ? high : lo9[7:0]};
      end
      default: begin
        count_step = {1'b0, high, low};
      end
    endcase
  endfunction

  // ----------------------------------------
  // Count enables
  // ----------------------------------------
  assign mode0 = dtec_pkg::dtec_mode_t'(mode_register_reg[`DTEC_MODE_SEL0]);
  assign mode1 = dtec_pkg::dtec_mode_t'(mode_register_reg[`DTEC_MODE_SEL1]);

  assign en0 = run_bit_reg[0]
             & (!mode_register_reg[`DTEC_MODE_GATING_ENABLE] | pins.irq_level[0])
             & (mode_register_reg[`DTEC_MODE_SRC0] ? pins.cnt_fall[0]
                                                     : pins.per_tick);
  assign en1 = run_bit_reg[1]
             & (!mode_register_reg[`DTEC_MODE_GATE1] | pins.irq_level[1])
             & (mode_register_reg[`DTEC_MODE_SRC1] ? pins.cnt_fall[1]
                                                     : pins.per_tick);
  // Split mode: channel 0 high byte is a timer run by channel 1 run bit.
  assign en0_high = run_bit_reg[1] & pins.per_tick;

  assign step0 = count_step(mode0, c0_high_reg, c0_low_reg);
  assign step1 = count_step(mode1, c1_high_reg, c1_low_reg);

  // ----------------------------------------
  // Count next values
  // ----------------------------------------
  always_comb begin
    c0_low_next  = c0_low_reg;
    c0_high_next = c0_high_reg;
    c1_low_next  = c1_low_reg;
    c1_high_next = c1_high_reg;
    ovf_evt      = 2'b00;
    if (mode0 == dtec_pkg::DTEC_MODE_SPLIT) begin
      if (en0) begin
        {ovf_evt[0], c0_low_next} = {1'b0, c0_low_reg} + 9'h001;
      end
      if (en0_high) begin
        {ovf_evt[1], c0_high_next} = {1'b0, c0_high_reg} + 9'h001;
      end
    end else if (en0) begin
      {ovf_evt[0], c0_high_next, c0_low_next} = step0;
    end
    // Channel 1 holds in split mode and loses its flag to channel 0.
    if (en1 && mode1 != dtec_pkg::DTEC_MODE_SPLIT) begin
      c1_high_next = step1[15:8];
      c1_low_next  = step1[7:0];
      if (mode0 != dtec_pkg::DTEC_MODE_SPLIT) begin
        ovf_evt[1] = step1[16];
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        `DTEC_ADDR_C0_LOW:  c0_low_next  = reg_wdata;
        `DTEC_ADDR_C0_HIGH: c0_high_next = reg_wdata;
        `DTEC_ADDR_C1_LOW:  c1_low_next  = reg_wdata;
        `DTEC_ADDR_C1_HIGH: c1_high_next = reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Count registers
  // ----------------------------------------
  // run bit keeps count
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      c0_low_reg  <= `DTEC_RST_BYTE;
      c0_high_reg <= `DTEC_RST_BYTE;
      c1_low_reg  <= `DTEC_RST_BYTE;
      c1_high_reg <= `DTEC_RST_BYTE;
    end else begin
      c0_low_reg  <= c0_low_next;
      c0_high_reg <= c0_high_next;
      c1_low_reg  <= c1_low_next;
      c1_high_reg <= c1_high_next;
    end
  end

  // ----------------------------------------
  // Mode and control registers
  // ----------------------------------------
  // mode and control for both channels
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mode_register_reg <= `DTEC_RST_BYTE;
      run_bit_reg       <= 2'b00;
      ext_irq_type_reg  <= 2'b00;
    end else if (reg_wr) begin
      if (reg_addr == `DTEC_ADDR_MODE) begin
        mode_register_reg <= reg_wdata;
      end
      if (reg_addr == `DTEC_ADDR_CTRL) begin
        run_bit_reg      <= {reg_wdata[`DTEC_CTRL_RUN1],
                             reg_wdata[`DTEC_CTRL_RUN0]};
        ext_irq_type_reg <= {reg_wdata[`DTEC_CTRL_ITYPE1],
                             reg_wdata[`DTEC_CTRL_ITYPE0]};
      end
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // Edge type sets the flag on a falling edge; level type follows the pin.
  assign ext_evt = (ext_irq_type_reg & pins.irq_fall)
                 | (~ext_irq_type_reg & ~pins.irq_level);

  // rollover sets flag
  // A hardware set in the cycle of a software clear wins.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      overflow_flag_reg <= 2'b00;
      ext_irq_flag_reg  <= 2'b00;
    end else begin
      if (reg_wr && reg_addr == `DTEC_ADDR_CTRL) begin
        overflow_flag_reg <= ovf_evt | {reg_wdata[`DTEC_CTRL_OVF1],
                                        reg_wdata[`DTEC_CTRL_OVF0]};
        ext_irq_flag_reg  <= ext_evt | {reg_wdata[`DTEC_CTRL_IFLAG1],
                                        reg_wdata[`DTEC_CTRL_IFLAG0]};
      end else begin
        overflow_flag_reg <= overflow_flag_reg | ovf_evt;
        ext_irq_flag_reg  <= (ext_irq_flag_reg & ext_irq_type_reg)
                           | ext_evt;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  always_comb begin
    status_next = status_reg;
    if (reg_rd && reg_addr == `DTEC_ADDR_STATUS) begin
      status_next = `DTEC_RST_IRQ;
    end
    status_next = status_next | {ext_evt & ~ext_irq_flag_reg, ovf_evt};
    mask_next = mask_reg;
    if (reg_wr && reg_addr == `DTEC_ADDR_MASK) begin
      mask_next = reg_wdata[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      status_reg <= `DTEC_RST_IRQ;
      mask_reg   <= `DTEC_RST_IRQ;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq        <= |(status_next & mask_next);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // both channels visible
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata <= `DTEC_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `DTEC_ADDR_MODE:    reg_rdata <= mode_register_reg;
        `DTEC_ADDR_CTRL:    reg_rdata <= {overflow_flag_reg[1],
                                          run_bit_reg[1],
                                          overflow_flag_reg[0],
                                          run_bit_reg[0],
                                          ext_irq_flag_reg[1],
                                          ext_irq_type_reg[1],
                                          ext_irq_flag_reg[0],
                                          ext_irq_type_reg[0]};
        `DTEC_ADDR_C0_LOW:  reg_rdata <= c0_low_reg;
        `DTEC_ADDR_C0_HIGH: reg_rdata <= c0_high_reg;
        `DTEC_ADDR_C1_LOW:  reg_rdata <= c1_low_reg;
        `DTEC_ADDR_C1_HIGH: reg_rdata <= c1_high_reg;
        `DTEC_ADDR_STATUS:  reg_rdata <= {4'h0, status_reg};
        `DTEC_ADDR_MASK:    reg_rdata <= {4'h0, mask_reg};
        default:            reg_rdata <= `DTEC_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `DTEC_RST_BYTE;
    end
  end

endmodule

// ==== sim/dtec_pin_model.sv ====
`timescale 1ns/100ps

module dtec_pin_model (
  // Clock
  input  wire logic       mclk,
  // Pins
  output logic      [1:0] count_pin,
  output logic      [1:0] ext_irq_pin_n
);
  initial begin
    count_pin     = 2'h3;
    ext_irq_pin_n = 2'h3;
  end

  task automatic pulses(input int ch, input int n);
    repeat (n) begin
      repeat (8) @(posedge mclk);
      count_pin[ch] <= 1'b0;
      repeat (8) @(posedge mclk);
      count_pin[ch] <= 1'b1;
    end
  endtask

  task automatic gate(input int ch, input logic lvl);
    @(posedge mclk);
    ext_irq_pin_n[ch] <= lvl;
  endtask
endmodule

// ==== sim/dtec_chk.sv ====
`timescale 1ns/100ps
`include "dtec_params.svh"

module dtec_chk (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  // Pins and interrupt
  input  wire logic [1:0] count_pin,
  input  wire logic [1:0] ext_irq_pin_n,
  input  wire logic       irq
);
  logic [7:0] mode_sh;
  logic [1:0] run_sh;
  logic [3:0] mask_sh;

  // Shadows of what software last wrote.
  always_ff @(posedge mclk) begin
    if (!rstn)
      mode_sh <= 8'h00;
    else if (reg_wr && reg_addr == `DTEC_ADDR_MODE)
      mode_sh <= reg_wdata;
  end
  always_ff @(posedge mclk) begin
    if (!rstn)
      run_sh <= 2'h0;
    else if (reg_wr && reg_addr == `DTEC_ADDR_CTRL)
      run_sh <= {reg_wdata[6], reg_wdata[4]};
  end
  always_ff @(posedge mclk) begin
    if (!rstn)
      mask_sh <= 4'h0;
    else if (reg_wr && reg_addr == `DTEC_ADDR_MASK)
      mask_sh <= reg_wdata[3:0];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_irq_reset: assert property (
    !$past(rstn) |-> !irq && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  a_mode_read: assert property (
    reg_rd && reg_addr == `DTEC_ADDR_MODE |=> reg_rdata == mode_sh)
    else $error("mode register read mismatch");
  a_ctrl_run: assert property (
    reg_rd && reg_addr == `DTEC_ADDR_CTRL
      |=> {reg_rdata[6], reg_rdata[4]} == run_sh)
    else $error("run bits read mismatch");
  a_mask_read: assert property (
    reg_rd && reg_addr == `DTEC_ADDR_MASK |=> reg_rdata[3:0] == mask_sh)
    else $error("mask register read mismatch");
  a_irq_masked: assert property (
    irq |-> mask_sh != 4'h0)
    else $error("interrupt with all sources masked");
  a_mask_off: assert property (
    reg_wr && reg_addr == `DTEC_ADDR_MASK && reg_wdata[3:0] == 4'h0
      |-> ##2 !irq)
    else $error("interrupt stays after masking");
  a_irq_hold: assert property (
    irq && !reg_rd && !reg_wr && !$past(reg_rd) && !$past(reg_wr)
      |=> irq)
    else $error("interrupt dropped without software");
endmodule

bind dtec_top dtec_chk i_dtec_chk (.mclk(mclk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_pin(count_pin),
  .ext_irq_pin_n(ext_irq_pin_n), .irq(irq));

// ==== sim/test_dual_timer_event_counter.sv ====
`timescale 1ns/100ps
`include "dtec_params.svh"

module test_dual_timer_event_counter;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] count_pin;
  logic [1:0] ext_irq_pin_n;
  logic       irq;
  logic [7:0] rv;
  logic [7:0] prev;
  int         num_errors = 0;
  int         num_checks = 0;

  always #5 mclk = ~mclk;

  dtec_top i_dtec_top (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .count_pin(count_pin),
    .ext_irq_pin_n(ext_irq_pin_n), .irq(irq));
  dtec_pin_model i_dtec_pin_model (.mclk(mclk), .count_pin(count_pin),
    .ext_irq_pin_n(ext_irq_pin_n));

  // ----------------------------------------
  // Shared bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
    @(posedge mclk);
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wait_irq(input int lim);
    int k;
    for (k = 0; k < lim && irq !== 1'b1; k++)
      @(posedge mclk);
    if (k == lim) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      conclude();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0]);
      chk(rv, `DTEC_RST_BYTE);
    end
    $display("reset test done");
  endtask

  task automatic t_timer();
    wr(`DTEC_ADDR_MASK, 8'h01);
    wr(`DTEC_ADDR_MODE, 8'h01);
    wr(`DTEC_ADDR_C0_LOW, 8'hFE);
    wr(`DTEC_ADDR_C0_HIGH, 8'hFF);
    wr(`DTEC_ADDR_CTRL, 8'h10);
    wait_irq(40);
    repeat (2) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    rd(`DTEC_ADDR_CTRL);
    chk(rv, 8'h30);
    wr(`DTEC_ADDR_CTRL, 8'h00);
    rd(`DTEC_ADDR_C0_HIGH);
    chk(rv, 8'h00);
    rd(`DTEC_ADDR_STATUS);
    chk(rv, 8'h01);
    rd(`DTEC_ADDR_STATUS);
    chk(rv, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(`DTEC_ADDR_MASK, 8'h00);
    $display("timer overflow test done");
  endtask

  task automatic t_rate();
    wr(`DTEC_ADDR_MODE, 8'h01);
    wr(`DTEC_ADDR_C0_LOW, 8'h00);
    wr(`DTEC_ADDR_C0_HIGH, 8'h00);
    wr(`DTEC_ADDR_CTRL, 8'h10);
    repeat (58) @(posedge mclk);
    wr(`DTEC_ADDR_CTRL, 8'h00);
    rd(`DTEC_ADDR_C0_LOW);
    chk(rv, 8'h0A);
    prev = rv;
    wr(`DTEC_ADDR_CTRL, 8'h10);
    repeat (10) @(posedge mclk);
    wr(`DTEC_ADDR_CTRL, 8'h00);
    rd(`DTEC_ADDR_C0_LOW);
    chk(rv, prev + 8'h02);
    $display("timer rate test done");
  endtask

  task automatic t_mode0();
    wr(`DTEC_ADDR_MODE, 8'h00);
    wr(`DTEC_ADDR_C0_LOW, 8'hFF);
    wr(`DTEC_ADDR_C0_HIGH, 8'h00);
    wr(`DTEC_ADDR_CTRL, 8'h10);
    repeat (4) @(posedge mclk);
    wr(`DTEC_ADDR_CTRL, 8'h00);
    rd(`DTEC_ADDR_C0_HIGH);
    chk(rv, 8'h01);
    rd(`DTEC_ADDR_C0_LOW);
    chk({3'h0, rv[4:0]}, 8'h00);
    $display("mode zero test done");
  endtask

  task automatic t_counter();
    // Channel is stopped before every mode change.
    wr(`DTEC_ADDR_MODE, 8'h05);
    wr(`DTEC_ADDR_C0_LOW, 8'h00);
    wr(`DTEC_ADDR_C0_HIGH, 8'h00);
    wr(`DTEC_ADDR_CTRL, 8'h10);
    i_dtec_pin_model.pulses(0, 5);
    repeat (20) @(posedge mclk);
    wr(`DTEC_ADDR_CTRL, 8'h00);
    rd(`DTEC_ADDR_C0_LOW);
    chk(rv, 8'h05);
    rd(`DTEC_ADDR_C1_LOW);
    chk(rv, 8'h00);
    wr(`DTEC_ADDR_MODE, 8'h0D);
    wr(`DTEC_ADDR_CTRL, 8'h10);
    i_dtec_pin_model.gate(0, 1'b0);
    i_dtec_pin_model.pulses(0, 3);
    i_dtec_pin_model.gate(0, 1'b1);
    i_dtec_pin_model.pulses(0, 2);
    repeat (20) @(posedge mclk);
    wr(`DTEC_ADDR_CTRL, 8'h00);
    rd(`DTEC_ADDR_C0_LOW);
    chk(rv, 8'h07);
    $display("event counter test done");
  endtask

  task automatic t_reload();
    rd(`DTEC_ADDR_STATUS);
    wr(`DTEC_ADDR_MASK, 8'h02);
    wr(`DTEC_ADDR_MODE, 8'h20);
    wr(`DTEC_ADDR_C1_LOW, 8'hFE);
    wr(`DTEC_ADDR_C1_HIGH, 8'hFE);
    wr(`DTEC_ADDR_CTRL, 8'h40);
    repeat (14) @(posedge mclk);
    rd(`DTEC_ADDR_CTRL);
    chk(rv, 8'hC0);
    wr(`DTEC_ADDR_CTRL, 8'h00);
    chk({7'h00, irq}, 8'h01);
    rd(`DTEC_ADDR_C1_LOW);
    chk(rv, 8'hFF);
    rd(`DTEC_ADDR_C1_HIGH);
    chk(rv, 8'hFE);
    rd(`DTEC_ADDR_STATUS);
    chk(rv, 8'h02);
    $display("reload mode test done");
  endtask

  task automatic t_split();
    wr(`DTEC_ADDR_MODE, 8'h33);
    wr(`DTEC_ADDR_C0_LOW, 8'h00);
    wr(`DTEC_ADDR_C0_HIGH, 8'hFF);
    wr(`DTEC_ADDR_CTRL, 8'h50);
    repeat (16) @(posedge mclk);
    wr(`DTEC_ADDR_CTRL, 8'h00);
    rd(`DTEC_ADDR_C0_LOW);
    chk(rv, 8'h03);
    rd(`DTEC_ADDR_C0_HIGH);
    chk(rv, 8'h02);
    rd(`DTEC_ADDR_C1_LOW);
    chk(rv, 8'hFF);
    rd(`DTEC_ADDR_STATUS);
    chk(rv, 8'h02);
    $display("split mode test done");
  endtask

  task automatic t_ext();
    wr(`DTEC_ADDR_MASK, 8'h04);
    wr(`DTEC_ADDR_CTRL, 8'h01);
    i_dtec_pin_model.gate(0, 1'b0);
    repeat (20) @(posedge mclk);
    i_dtec_pin_model.gate(0, 1'b1);
    repeat (20) @(posedge mclk);
    chk({7'h00, irq}, 8'h01);
    rd(`DTEC_ADDR_CTRL);
    chk(rv, 8'h03);
    rd(`DTEC_ADDR_STATUS);
    chk(rv, 8'h04);
    wr(`DTEC_ADDR_CTRL, 8'h00);
    rd(`DTEC_ADDR_CTRL);
    chk(rv, 8'h00);
    $display("edge interrupt test done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_timer();
    t_rate();
    t_mode0();
    t_counter();
    t_reload();
    t_split();
    t_ext();
    conclude();
  end
endmodule
